// *** bench/link_event_source.sv ***
// Stand-in for the remote link side, offering events by valid/ready
module link_event_source (
  input wire logic core_clk,
  input wire logic evtReady,
  output lrr_pkg::link_evt_t linkEvt,
  output logic evtValid
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    linkEvt = '0;
    evtValid = 1'b0;
  end

  // Payload is scrambled once released so stale values cannot pass
  task automatic send(input lrr_pkg::link_evt_t ev, output logic ok);
    ok = 1'b0;
    @(posedge core_clk);
    linkEvt <= ev;
    evtValid <= 1'b1;
    for (int i = 0; i < 50 && !ok; i++) begin
      @(posedge core_clk);
      ok = (evtReady === 1'b1);
    end
    evtValid <= 1'b0;
    linkEvt <= ~ev;
  endtask
endmodule // link_event_source

// *** bench/tb.sv ***
// Self-checking bench for the link control response reporter
module tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic core_clk;
  logic reset_n;
  lrr_pkg::apb_req_t apbReq;
  logic [31:0] prdata;
  logic pready, pslverr;
  lrr_pkg::link_evt_t linkEvt;
  logic evtValid, evtReady, bufReturn, discardMsg;
  logic [7:0] bufReturnTrib;
  int mismatches = 0;
  int nCompared = 0;
  logic [3:0] ctrlVal;
  logic [31:0] rd;
  logic err;
  logic [21:0] a = 22'h3abcde;

  link_response_reporter link_response_reporter_i (
    .core_clk(core_clk), .reset_n(reset_n), .apbReq(apbReq),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .linkEvt(linkEvt), .evtValid(evtValid), .evtReady(evtReady),
    .bufReturn(bufReturn), .bufReturnTrib(bufReturnTrib),
    .discardMsg(discardMsg));

  link_event_source link_event_source_i (
    .core_clk(core_clk), .evtReady(evtReady), .linkEvt(linkEvt),
    .evtValid(evtValid));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (mismatches == 0 && nCompared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string n, input logic [31:0] s, e);
    nCompared++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic busXfer(input logic [7:0] ad, input logic w,
                         input logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge core_clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: ad, pwdata: d};
    @(posedge core_clk);
    apbReq.penable <= 1'b1;
    for (int i = 0; i < 20 && !done; i++) begin
      @(posedge core_clk);
      done = (pready === 1'b1);
    end
    rd = prdata;
    err = pslverr;
    apbReq <= '0;
    if (!done) begin
      mismatches++;
      conclude();
    end
  endtask

  task automatic rdChk(input logic [7:0] ad, input logic [31:0] m, e,
                       input string n);
    busXfer(ad, 1'b0, 32'h0);
    check(n, rd & m, e);
  endtask

  task automatic ev(input lrr_pkg::evt_kind_t k, input logic [7:0] t,
                    input logic [21:0] ad);
    logic ok;
    link_event_source_i.send('{kind: k, trib: t, addr: ad}, ok);
    if (!ok) begin
      mismatches++;
      conclude();
    end
  endtask

  // In 22-bit mode the code moves to the extended byte
  task automatic expectResp(input logic [7:0] c, t, input logic [21:0] ad);
    logic [7:0] tr;
    tr = ctrlVal[1] ? t : 8'h01;
    busXfer(lrr_pkg::OFS_RESP_HEAD, 1'b0, 32'h0);
    if (ctrlVal[0])
      check("head", rd, {1'b1, 7'h00, c, tr, 8'h00});
    else
      check("head", rd, {1'b1, 7'h00, 8'h00, tr, c});
    rdChk(lrr_pkg::OFS_ADDR_LOW, '1, {16'h0, ad[15:0]}, "low");
    if (ctrlVal[0])
      rdChk(lrr_pkg::OFS_CNT_ADDR, '1, {26'h0, ad[21:16]}, "cnt");
    else
      rdChk(lrr_pkg::OFS_CNT_ADDR, '1, {18'h0, ad[21:16], 8'h0}, "cnt");
    busXfer(lrr_pkg::OFS_POP, 1'b1, 32'h0);
  endtask

  task automatic noResp();
    rdChk(lrr_pkg::OFS_RESP_HEAD, 32'h80000000, 32'h0, "none");
  endtask

  task automatic cnt(input int lsb, input logic [31:0] e);
    rdChk(lrr_pkg::OFS_STATUS, 32'h7 << lsb, e << lsb, "count");
  endtask

  task automatic setCtrl(input logic [3:0] v);
    ctrlVal = v;
    busXfer(lrr_pkg::OFS_CTRL, 1'b1, {28'h0, v});
  endtask

  task automatic cmd(input logic [7:0] t, input logic [1:0] c);
    busXfer(lrr_pkg::OFS_TRIB_CMD, 1'b1, {22'h0, c, t});
  endtask

  task automatic stChk(input logic [7:0] t, input lrr_pkg::trib_state_t s);
    rdChk(lrr_pkg::OFS_TRIB_CMD, 32'h70ff, {17'h0, s, 4'h0, t}, "state");
  endtask

  // Pulses stand for one cycle only, so both cycles are looked at
  task automatic pulses(input logic [1:0] e, input logic [7:0] t);
    @(posedge core_clk);
    check("pulse", {30'h0, bufReturn, discardMsg}, {30'h0, e});
    if (e[1])
      check("bufTrib", {24'h0, bufReturnTrib}, {24'h0, t});
    @(posedge core_clk);
    check("pulseEnd", {30'h0, bufReturn, discardMsg}, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    apbReq = '0;
    ctrlVal = 4'h0;
    reset_n = 1'b0;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    rdChk(lrr_pkg::OFS_CTRL, '1, 32'h0, "ctrl");
    rdChk(lrr_pkg::OFS_STATUS, '1, 32'h0, "status");
    noResp();
    busXfer(8'h1c, 1'b0, 32'h0);
    check("slverr", {31'h0, err}, 32'h1);
    check("badRead", rd, 32'h0);
    for (int k = 0; k < 3; k++) begin
      repeat (6) ev(lrr_pkg::evt_kind_t'(2 * k), 8'h05, a);
      cnt(8 - 4 * k, 6);
      ev(lrr_pkg::evt_kind_t'(2 * k + 1), 8'h05, a);
      cnt(8 - 4 * k, 0);
      noResp();
      repeat (7) ev(lrr_pkg::evt_kind_t'(2 * k), 8'h05, a);
      expectResp(8'(2 * k + 2), 8'h05, a);
      cnt(8 - 4 * k, 0);
    end
    setCtrl(4'h6);
    cmd(8'h03, lrr_pkg::CMD_START);
    stChk(8'h03, lrr_pkg::TS_ISTRT);
    repeat (7) ev(lrr_pkg::EV_TX_ERR, 8'h03, a);
    expectResp(8'h04, 8'h03, a);
    cnt(4, 7);
    ev(lrr_pkg::EV_TX_ERR, 8'h03, a);
    expectResp(8'h04, 8'h03, a);
    ev(lrr_pkg::EV_TX_OK, 8'h03, a);
    cnt(4, 0);
    cmd(8'h02, lrr_pkg::CMD_START);
    ev(lrr_pkg::EV_STARTUP_DONE, 8'h02, a);
    expectResp(8'h14, 8'h02, a);
    stChk(8'h02, lrr_pkg::TS_RUN);
    ev(lrr_pkg::EV_START_MSG, 8'h02, a);
    pulses(2'b10, 8'h02);
    expectResp(8'h08, 8'h02, a);
    stChk(8'h02, lrr_pkg::TS_HALTED);
    ev(lrr_pkg::EV_MAINT_MSG, 8'h02, a);
    pulses(2'b01, 8'h02);
    expectResp(8'h0c, 8'h02, a);
    stChk(8'h02, lrr_pkg::TS_MAINT);
    ev(lrr_pkg::EV_START_MSG, 8'h02, a);
    pulses(2'b00, 8'h02);
    expectResp(8'h0e, 8'h02, a);
    stChk(8'h02, lrr_pkg::TS_MAINT);
    cmd(8'h02, lrr_pkg::CMD_HALT);
    cmd(8'h02, lrr_pkg::CMD_START);
    ev(lrr_pkg::EV_MAINT_MSG, 8'h02, a);
    pulses(2'b11, 8'h02);
    expectResp(8'h0a, 8'h02, a);
    stChk(8'h02, lrr_pkg::TS_MAINT);
    ev(lrr_pkg::EV_POLL_DEAD, 8'h04, a);
    expectResp(8'h12, 8'h04, a);
    ev(lrr_pkg::EV_BABBLE, 8'h04, a);
    expectResp(8'h16, 8'h04, a);
    ev(lrr_pkg::EV_STREAM, 8'h04, a);
    expectResp(8'h18, 8'h04, a);
    setCtrl(4'h8);
    ev(lrr_pkg::EV_POLL_DEAD, 8'h04, a);
    noResp();
    ev(lrr_pkg::EV_BABBLE, 8'h04, a);
    expectResp(8'h16, 8'h04, a);
    setCtrl(4'h1);
    ev(lrr_pkg::EV_STREAM, 8'h04, a);
    noResp();
    setCtrl(4'h9);
    ev(lrr_pkg::EV_STREAM, 8'h04, 22'h2a5a5a);
    expectResp(8'h18, 8'h04, 22'h2a5a5a);
    setCtrl(4'h6);
    for (int i = 0; i < 4; i++)
      ev(lrr_pkg::EV_POLL_DEAD, 8'(i + 1), a);
    @(posedge core_clk);
    check("full", {31'h0, evtReady}, 32'h0);
    rdChk(lrr_pkg::OFS_STATUS, 32'hf000, 32'h4000, "qcount");
    fork
      ev(lrr_pkg::EV_POLL_DEAD, 8'h05, a);
    join_none
    for (int i = 0; i < 5; i++)
      expectResp(8'h12, 8'(i + 1), a);
    noResp();
    conclude();
  end
endmodule // tb

// *** hw/consec_err_counter.sv ***
// Saturating consecutive error counter with threshold hit pulse
module consec_err_counter #(
  parameter int W = 3,
  parameter int THRESH = lrr_pkg::ERR_THRESHOLD
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic err,
  input wire logic good,
  input wire logic clrOnHit,
  output logic hit,
  output logic [W-1:0] count
);
  localparam logic [W-1:0] TOP = W'(THRESH);
  localparam logic [W-1:0] PRE = W'(THRESH - 1);
  logic [W-1:0] next_count;

  assign hit = err && (count >= PRE);
  // With clrOnHit low, held at the threshold, every further error reports again
  assign next_count = (hit && clrOnHit) ? '0 :
                      err ? ((count == TOP) ? TOP : count + W'(1)) :
                      good ? '0 : count;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
endmodule // consec_err_counter

// *** hw/link_response_reporter.sv ***
// Link event to control response reporter with APB register access

////////////////////////////////////////////////////////////////////////////
module link_response_reporter #(
  parameter int NTRIB = 8,
  parameter int QDEPTH = 4
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire lrr_pkg::apb_req_t apbReq,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire lrr_pkg::link_evt_t linkEvt,
  input wire logic evtValid,
  output logic evtReady,
  output logic bufReturn,
  output logic [7:0] bufReturnTrib,
  output logic discardMsg
);
  localparam int TW = (NTRIB > 1) ? $clog2(NTRIB) : 1;
  localparam int QW = (QDEPTH > 1) ? $clog2(QDEPTH) : 1;
  localparam logic [QW:0] QFULL = (QW + 1)'(QDEPTH);
  localparam logic [QW-1:0] QLAST = QW'(QDEPTH - 1);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [3:0] ctrl;
  logic [7:0] cmdTrib;
  lrr_pkg::trib_state_t tribState [NTRIB];
  lrr_pkg::resp_t queue [QDEPTH];
  logic [QW-1:0] wrPtr;
  logic [QW-1:0] rdPtr;
  logic [QW:0] qCount;
  logic [2:0] rxCount;
  logic [2:0] txCount;
  logic [2:0] selCount;
  logic rxHit;
  logic txHit;
  logic selHit;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire access = apbReq.psel && apbReq.penable;
  wire wrAccess = access && apbReq.pwrite;
  wire hitCtrl = apbReq.paddr == lrr_pkg::OFS_CTRL;
  wire hitHead = apbReq.paddr == lrr_pkg::OFS_RESP_HEAD;
  wire hitAddr = apbReq.paddr == lrr_pkg::OFS_ADDR_LOW;
  wire hitCnt = apbReq.paddr == lrr_pkg::OFS_CNT_ADDR;
  wire hitPop = apbReq.paddr == lrr_pkg::OFS_POP;
  wire hitCmd = apbReq.paddr == lrr_pkg::OFS_TRIB_CMD;
  wire hitStat = apbReq.paddr == lrr_pkg::OFS_STATUS;
  wire mapped = hitCtrl || hitHead || hitAddr || hitCnt || hitPop ||
                hitCmd || hitStat;
  wire qEmpty = qCount == '0;
  wire qFull = qCount == QFULL;
  wire pop = wrAccess && hitPop && !qEmpty;
  wire cmdWrite = wrAccess && hitCmd;
  wire [1:0] cmdCode = apbReq.pwdata[lrr_pkg::CMD_LSB +: 2];
  wire [TW-1:0] cmdIdx = apbReq.pwdata[TW-1:0];
  wire addr22 = ctrl[lrr_pkg::CTRL_ADDR22_BIT];
  wire multi = ctrl[lrr_pkg::CTRL_MULTI_BIT];
  wire ctlStation = ctrl[lrr_pkg::CTRL_CONTROL_BIT];
  wire halfDup = ctrl[lrr_pkg::CTRL_HALFDUP_BIT];
  lrr_pkg::resp_t head;
  assign head = queue[rdPtr];

  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata =
    !access ? 32'h0 :
    hitCtrl ? {28'h0, ctrl} :
    hitHead ? {!qEmpty, 7'h0, head.extended_response_code_byte,
               head.tributary_id_byte, head.response_code_byte} :
    hitAddr ? {16'h0, head.buffer_address_low_word} :
    hitCnt ? {16'h0, head.count_and_upper_address_word} :
    hitCmd ? {17'h0, tribState[cmdTrib[TW-1:0]], 4'h0, cmdTrib} :
    hitStat ? {16'h0, 4'(qCount), 1'b0, rxCount, 1'b0, txCount,
               1'b0, selCount} :
    32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Event classification
  wire accept = evtValid && evtReady;
  wire [TW-1:0] idx = linkEvt.trib[TW-1:0];
  lrr_pkg::trib_state_t cur;
  assign cur = tribState[idx];
  wire isKind [12];
  for (genvar k = 0; k < 12; k++) begin : g_kind
    assign isKind[k] = accept && (linkEvt.kind == lrr_pkg::evt_kind_t'(k));
  end
  wire curRun = cur == lrr_pkg::TS_RUN;
  wire curStartup = (cur == lrr_pkg::TS_ISTRT) || (cur == lrr_pkg::TS_ASTRT);
  wire curMaint = cur == lrr_pkg::TS_MAINT;
  wire curHalted = cur == lrr_pkg::TS_HALTED;
  wire startRun = isKind[lrr_pkg::EV_START_MSG] && curRun;
  wire startMaint = isKind[lrr_pkg::EV_START_MSG] && curMaint;
  wire startInit = isKind[lrr_pkg::EV_START_MSG] &&
                   (cur == lrr_pkg::TS_ISTRT);
  wire maintActive = isKind[lrr_pkg::EV_MAINT_MSG] &&
                     (curRun || curStartup);
  wire maintHalted = isKind[lrr_pkg::EV_MAINT_MSG] && curHalted;
  wire pollDead = isKind[lrr_pkg::EV_POLL_DEAD] && multi && ctlStation;
  wire runDone = isKind[lrr_pkg::EV_STARTUP_DONE] && curStartup;
  wire babble = isKind[lrr_pkg::EV_BABBLE] && (halfDup || ctlStation);
  wire stream = isKind[lrr_pkg::EV_STREAM] && (halfDup || ctlStation);

  ////////////////////////////////////////////////////////////////////////////
  // Consecutive error counters
  consec_err_counter u_rx_cnt (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .err(isKind[lrr_pkg::EV_RX_ERR]),
    .good(isKind[lrr_pkg::EV_RX_OK]),
    .clrOnHit(1'b1),
    .hit(rxHit),
    .count(rxCount)
  );
  // Start, start-ack, NAK and reply timeouts all arrive as one error kind
  consec_err_counter u_tx_cnt (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .err(isKind[lrr_pkg::EV_TX_ERR]),
    .good(isKind[lrr_pkg::EV_TX_OK]),
    .clrOnHit(!curStartup),
    .hit(txHit),
    .count(txCount)
  );
  consec_err_counter u_sel_cnt (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .err(isKind[lrr_pkg::EV_SEL_TIMEOUT]),
    .good(isKind[lrr_pkg::EV_SEL_OK]),
    .clrOnHit(1'b1),
    .hit(selHit),
    .count(selCount)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Response selection and formatting
  // Events come one per cycle, so at most one condition is true at a time
  wire respWant = rxHit || txHit || selHit || startRun || maintActive ||
                  maintHalted || startMaint || pollDead || runDone ||
                  babble || stream;
  wire [7:0] respCode =
    rxHit ? lrr_pkg::CODE_RX_THRESH :
    txHit ? lrr_pkg::CODE_TX_THRESH :
    selHit ? lrr_pkg::CODE_SEL_THRESH :
    startRun ? lrr_pkg::CODE_START_RUN :
    maintActive ? lrr_pkg::CODE_MAINT_RUN :
    maintHalted ? lrr_pkg::CODE_MAINT_HALT :
    startMaint ? lrr_pkg::CODE_START_MAINT :
    pollDead ? lrr_pkg::CODE_POLL_DEAD :
    runDone ? lrr_pkg::CODE_RUN_ENTERED :
    babble ? lrr_pkg::CODE_BABBLE :
    lrr_pkg::CODE_STREAM;
  lrr_pkg::resp_t newResp;
  assign newResp.tributary_id_byte =
    multi ? linkEvt.trib : lrr_pkg::PTP_TRIB_ID;
  assign newResp.buffer_address_low_word = linkEvt.addr[15:0];
  assign newResp.count_and_upper_address_word = addr22 ?
    (16'(linkEvt.addr[21:16]) << lrr_pkg::CNT_UPPER_LSB_EXT) :
    (16'(linkEvt.addr[21:16]) << lrr_pkg::CNT_UPPER_LSB_STD);
  assign newResp.response_code_byte = addr22 ? 8'h00 : respCode;
  assign newResp.extended_response_code_byte =
    addr22 ? respCode : 8'h00;

  // Full queue stalls the event source instead of dropping a response
  assign evtReady = !qFull;
  wire push = accept && respWant;

  ////////////////////////////////////////////////////////////////////////////
  // Response queue
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      qCount <= '0;
    end else begin
      if (push) begin
        wrPtr <= (wrPtr == QLAST) ? '0 : wrPtr + QW'(1);
      end
      if (pop) begin
        rdPtr <= (rdPtr == QLAST) ? '0 : rdPtr + QW'(1);
      end
      qCount <= qCount + (QW + 1)'(push) - (QW + 1)'(pop);
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      queue[wrPtr] <= newResp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers and side effects
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= lrr_pkg::CTRL_RESET;
      cmdTrib <= 8'h00;
      bufReturn <= 1'b0;
      bufReturnTrib <= 8'h00;
      discardMsg <= 1'b0;
    end else begin
      if (wrAccess && hitCtrl) begin
        ctrl <= apbReq.pwdata[3:0];
      end
      if (cmdWrite) begin
        cmdTrib <= apbReq.pwdata[7:0];
      end
      bufReturn <= startRun || maintActive;
      bufReturnTrib <= linkEvt.trib;
      discardMsg <= maintActive || maintHalted;
    end
  end

  // Link events win over a host command aimed at the same tributary
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NTRIB; i++) begin
        tribState[i] <= lrr_pkg::TS_HALTED;
      end
    end else begin
      if (cmdWrite && cmdCode == lrr_pkg::CMD_START) begin
        tribState[cmdIdx] <= lrr_pkg::TS_ISTRT;
      end else if (cmdWrite && cmdCode == lrr_pkg::CMD_HALT) begin
        tribState[cmdIdx] <= lrr_pkg::TS_HALTED;
      end
      if (startRun) begin
        tribState[idx] <= lrr_pkg::TS_HALTED;
      end else if (maintActive || maintHalted) begin
        tribState[idx] <= lrr_pkg::TS_MAINT;
      end else if (runDone) begin
        tribState[idx] <= lrr_pkg::TS_RUN;
      end else if (startInit) begin
        tribState[idx] <= lrr_pkg::TS_ASTRT;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_rxSeventh;
    isKind[lrr_pkg::EV_RX_ERR] && rxCount == 3'd6;
  endsequence
  sequence s_txHeld;
    isKind[lrr_pkg::EV_TX_ERR] && txCount == 3'd6 && curStartup &&
    !cmdWrite;
  endsequence
  sequence s_startRun;
    isKind[lrr_pkg::EV_START_MSG] && curRun && !cmdWrite;
  endsequence

  a_rx_report: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_rxSeventh |-> push && respCode == 8'h02 ##1 rxCount == 3'd0)
    else $error("receive threshold not reported");
  a_tx_report: assert property (@(posedge core_clk) disable iff (!reset_n)
    isKind[lrr_pkg::EV_TX_ERR] && txCount == 3'd6 |-> push &&
    respCode == 8'h04)
    else $error("transmit threshold not reported");
  a_tx_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_txHeld |=> txCount == 3'd7)
    else $error("transmit counter cleared during start-up");
  a_sel_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
    isKind[lrr_pkg::EV_SEL_TIMEOUT] && selCount == 3'd6 |-> push &&
    respCode == 8'h06 ##1 selCount == 3'd0)
    else $error("select threshold not reported and cleared");
  a_start_halt: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_startRun |=> bufReturn && tribState[$past(idx)] ==
    lrr_pkg::TS_HALTED)
    else $error("start while running did not halt");
  a_maint_enter: assert property (@(posedge core_clk) disable iff (!reset_n)
    maintActive && !cmdWrite |-> respCode == 8'h0a ##1 discardMsg &&
    bufReturn && tribState[$past(idx)] == lrr_pkg::TS_MAINT)
    else $error("maintenance while active mishandled");
  a_start_maint: assert property (@(posedge core_clk) disable iff (!reset_n)
    startMaint |-> push ##1 !bufReturn && !discardMsg)
    else $error("start in maintenance took action");
  a_ptp_trib: assert property (@(posedge core_clk) disable iff (!reset_n)
    push && !multi |-> newResp.tributary_id_byte == 8'h01)
    else $error("point-to-point tributary byte not one");
  a_no_overrun: assert property (@(posedge core_clk) disable iff (!reset_n)
    qFull && !pop |=> qFull && !evtReady)
    else $error("full response queue lost an entry");
  a_ext_code: assert property (@(posedge core_clk) disable iff (!reset_n)
    push && addr22 |-> newResp.response_code_byte == 8'h00 &&
    newResp.extended_response_code_byte == respCode)
    else $error("extended code byte misplaced");
endmodule // link_response_reporter

// *** hw/lrr_pkg.sv ***
// Shared constants and types for the link control response reporter
package lrr_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RESP_HEAD = 8'h04;
  localparam logic [7:0] OFS_ADDR_LOW = 8'h08;
  localparam logic [7:0] OFS_CNT_ADDR = 8'h0c;
  localparam logic [7:0] OFS_POP = 8'h10;
  localparam logic [7:0] OFS_TRIB_CMD = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // Control register fields
  localparam int CTRL_ADDR22_BIT = 0;
  localparam int CTRL_MULTI_BIT = 1;
  localparam int CTRL_CONTROL_BIT = 2;
  localparam int CTRL_HALFDUP_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // Tributary command register fields
  localparam int CMD_LSB = 8;
  localparam logic [1:0] CMD_START = 2'h1;
  localparam logic [1:0] CMD_HALT = 2'h2;
  localparam int CMD_STATE_LSB = 12;

  // Response head register fields
  localparam int HEAD_TRIB_LSB = 8;
  localparam int HEAD_EXT_LSB = 16;
  localparam int HEAD_VALID_BIT = 31;
  localparam int CNT_UPPER_LSB_STD = 8;
  localparam int CNT_UPPER_LSB_EXT = 0;
  localparam logic [7:0] PTP_TRIB_ID = 8'h01;

  // Consecutive error threshold
  localparam int ERR_THRESHOLD = 7;

  // Response codes (octal 002 .. 030)
  localparam logic [7:0] CODE_RX_THRESH = 8'h02;
  localparam logic [7:0] CODE_TX_THRESH = 8'h04;
  localparam logic [7:0] CODE_SEL_THRESH = 8'h06;
  localparam logic [7:0] CODE_START_RUN = 8'h08;
  localparam logic [7:0] CODE_MAINT_RUN = 8'h0a;
  localparam logic [7:0] CODE_MAINT_HALT = 8'h0c;
  localparam logic [7:0] CODE_START_MAINT = 8'h0e;
  localparam logic [7:0] CODE_POLL_DEAD = 8'h12;
  localparam logic [7:0] CODE_RUN_ENTERED = 8'h14;
  localparam logic [7:0] CODE_BABBLE = 8'h16;
  localparam logic [7:0] CODE_STREAM = 8'h18;

  typedef enum logic [2:0] {
    TS_HALTED = 3'b000,
    TS_ISTRT = 3'b001,
    TS_ASTRT = 3'b010,
    TS_RUN = 3'b011,
    TS_MAINT = 3'b100
  } trib_state_t;

  typedef enum logic [3:0] {
    EV_RX_ERR = 4'h0,
    EV_RX_OK = 4'h1,
    EV_TX_ERR = 4'h2,
    EV_TX_OK = 4'h3,
    EV_SEL_TIMEOUT = 4'h4,
    EV_SEL_OK = 4'h5,
    EV_START_MSG = 4'h6,
    EV_MAINT_MSG = 4'h7,
    EV_POLL_DEAD = 4'h8,
    EV_STARTUP_DONE = 4'h9,
    EV_BABBLE = 4'ha,
    EV_STREAM = 4'hb
  } evt_kind_t;

  typedef struct packed {
    evt_kind_t kind;
    logic [7:0] trib;
    logic [21:0] addr;
  } link_evt_t;

  typedef struct packed {
    logic [7:0] tributary_id_byte;
    logic [15:0] buffer_address_low_word;
    logic [15:0] count_and_upper_address_word;
    logic [7:0] response_code_byte;
    logic [7:0] extended_response_code_byte;
  } resp_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

endpackage
